//--- hw/ccr_pkg.sv
// Register map, field layout and reset values of the charger configuration bank
// Behaviour
// R1: Input-control bit 1 set disables input-voltage watch; resets clear.
// R2: Input-control bit 0 set enters low-power USB standby; clear leaves it off.
// R3: Charge-current code: 0 to 5 give 250mA, then 50mA steps to 1.55A.
// R4: Charge-timer code 0 disables; 1 to 7 give 4 to 10 hours; default 2.
// R5: Restart select: clear restarts 150mV below regulation, set 100mV below.
// R6: Input-limit code: 0-9 100mA, 10 250mA, 25mA steps to 1500mA; 63 disables.
// R7: Input-limit trip point sits at 95 percent of the selected target.
// R8: Finish-timer code gives 0 to 70 minutes in 10-minute steps; default 30.
// R9: Finish bit 4 scales fast-charge maximum to 2.8A; pulsed test only.
// R10: Finish-current code selects 50, 100, 150 or 200mA; default 50mA.
// R11: Termination code selects 4.2V, 4.10V, 4.35V, 4.15V; default 4.2V.
// R12: Die setpoint code: 105C, 90C, 120C, code 3 disables; default 105C.
// R13: Thermal bit 3 set stops thermistor watch; reset value set by variant.
// R14: Thermal bit 0 selects safety region 1 when clear, 2 when set.
// R15: Key bits 3:2 unlock only when 11; other values lock; resets locked.
// R16: Key guards registers 0x06 to 0x09; control and key registers stay free.
// R17: Whole bank returns to defaults on standby loss or power-good rising.
// R18: Locked writes to guarded registers change nothing; reads still return contents.
package ccr_pkg;
   // ------------------------------------------------------------------
   // Offsets, reset values and writable bits
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTL = 8'h05;
   localparam logic [7:0] OFS_FAST = 8'h06;
   localparam logic [7:0] OFS_LIMIT = 8'h07;
   localparam logic [7:0] OFS_FINISH = 8'h08;
   localparam logic [7:0] OFS_THERMAL = 8'h09;
   localparam logic [7:0] OFS_LOCK = 8'h0a;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_FAST = 8'h4a;
   localparam logic [7:0] RST_LIMIT = 8'h14;
   localparam logic [7:0] RST_FINISH = 8'h60;
   localparam logic [7:0] RST_THERMAL = 8'h00;
   localparam logic [7:0] RST_LOCK = 8'h00;
   localparam logic [7:0] WMSK_CTL = 8'h03;
   localparam logic [7:0] WMSK_FAST = 8'hff;
   localparam logic [7:0] WMSK_LIMIT = 8'h7f;
   localparam logic [7:0] WMSK_FINISH = 8'hff;
   localparam logic [7:0] WMSK_THERMAL = 8'hc9;
   localparam logic [7:0] WMSK_LOCK = 8'h0c;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam logic [1:0] KEY_OPEN = 2'h3;
   // ------------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------------
   localparam int POS_STANDBY = 0;
   localparam int POS_WATCH_OFF = 1;
   localparam int POS_CUR = 0;
   localparam int W_CUR = 5;
   localparam int POS_TIMER = 5;
   localparam int W_TIMER = 3;
   localparam int POS_LIMIT = 0;
   localparam int W_LIMIT = 6;
   localparam int POS_RESTART = 6;
   localparam int POS_TERM = 0;
   localparam int W_TERM = 2;
   localparam int POS_FCUR = 2;
   localparam int W_FCUR = 2;
   localparam int POS_SCALE = 4;
   localparam int POS_FTIMER = 5;
   localparam int W_FTIMER = 3;
   localparam int POS_SAFETY = 0;
   localparam int POS_THERM_OFF = 3;
   localparam int POS_SETPT = 6;
   localparam int W_SETPT = 2;
   localparam int POS_KEY = 2;
   localparam int W_KEY = 2;
endpackage

//--- hw/ccr_cfg_if.sv
// Interface carrying register contents to the decoder and settings back
`timescale 1ns/1ps
interface ccr_cfg_if;
   logic [7:0] fast_charge;
   logic [7:0] input_limit;
   logic [7:0] finish;
   logic [7:0] thermal;
   logic [11:0] charge_ma;
   logic [3:0] timer_hours;
   logic timer_on;
   logic [7:0] restart_mv;
   logic [10:0] limit_ma;
   logic [10:0] trip_ma;
   logic limit_on;
   logic [6:0] finish_min;
   logic [7:0] finish_ma;
   logic [12:0] term_mv;
   logic [6:0] setpt_c;
   logic setpt_on;
   modport regs (output fast_charge, input_limit, finish, thermal,
      input charge_ma, timer_hours, timer_on, restart_mv, limit_ma, trip_ma,
      limit_on, finish_min, finish_ma, term_mv, setpt_c, setpt_on);
   modport dec (input fast_charge, input_limit, finish, thermal,
      output charge_ma, timer_hours, timer_on, restart_mv, limit_ma, trip_ma,
      limit_on, finish_min, finish_ma, term_mv, setpt_c, setpt_on);
endinterface

//--- hw/ccr_bank_reset.sv
// Bank clear generator: standby supply loss or power-good rising edge
`timescale 1ns/1ps
module ccr_bank_reset (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Clear sources
   input wire logic i_standby_supply_valid,
   input wire logic i_safe_output_power_good,
   // Clear to the bank
   output logic o_bank_clear
);
   logic pg_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pg_q <= 1'b0;
         o_bank_clear <= 1'b1;
      end else begin
         pg_q <= i_safe_output_power_good;
         o_bank_clear <= !i_standby_supply_valid ||
            (i_safe_output_power_good && !pg_q);  // see R17
      end
   end
endmodule

//--- hw/ccr_decode.sv
// Decoder turning configuration codes into physical settings
`timescale 1ns/1ps
module ccr_decode (
   // Clock
   input wire logic i_clk_sys,
   // Register contents in, settings out
   ccr_cfg_if.dec cfg
);
   localparam int CUR_BASE = 12'h0fa;
   localparam int CUR_STEP = 8'h32;
   localparam int CUR_FLOOR = 4'h5;
   localparam int CUR_TEST = 12'haf0;
   localparam int HOUR_OFS = 4'h3;
   localparam int LIM_LOW = 8'h64;
   localparam int LIM_LOW_LAST = 4'h9;
   localparam int LIM_BASE = 12'h0fa;
   localparam int LIM_STEP = 8'h19;
   localparam int LIM_TOP = 8'h3c;
   localparam logic [5:0] LIM_OFF = 6'h3f;
   localparam int TRIP_PCT = 8'h5f;
   localparam int PCT = 8'h64;
   localparam int MIN_STEP = 8'h0a;
   localparam int FCUR_STEP = 8'h32;
   localparam logic [7:0] RESTART_MV [2] = '{8'h96, 8'h64};
   localparam logic [12:0] TERM_MV [4] = '{13'h1068, 13'h1004, 13'h10fe, 13'h1036};
   localparam logic [6:0] SETPT_C [4] = '{7'h69, 7'h5a, 7'h78, 7'h00};
   localparam logic [1:0] SETPT_OFF = 2'h3;

   function automatic logic [11:0] charge_ma(input logic [4:0] c, input logic scale);
      int k;
      k = (int'(c) > CUR_FLOOR) ? int'(c) - CUR_FLOOR : 0;
      return scale ? 12'(CUR_TEST) : 12'(CUR_BASE + CUR_STEP * k);
   endfunction

   // Codes above the top step (undefined ones) hold the top value
   function automatic logic [10:0] limit_ma(input logic [5:0] c);
      int k;
      k = (int'(c) > LIM_TOP) ? LIM_TOP : int'(c);
      return (k <= LIM_LOW_LAST) ? 11'(LIM_LOW) :
         11'(LIM_BASE + LIM_STEP * (k - LIM_LOW_LAST - 1));
   endfunction

   logic [5:0] lim_code;
   logic [2:0] tmr_code;
   logic [1:0] set_code;
   assign lim_code = cfg.input_limit[ccr_pkg::POS_LIMIT +: ccr_pkg::W_LIMIT];
   assign tmr_code = cfg.fast_charge[ccr_pkg::POS_TIMER +: ccr_pkg::W_TIMER];
   assign set_code = cfg.thermal[ccr_pkg::POS_SETPT +: ccr_pkg::W_SETPT];

   always_ff @(posedge i_clk_sys) begin
      cfg.charge_ma <= charge_ma(cfg.fast_charge[ccr_pkg::POS_CUR +: ccr_pkg::W_CUR],
         cfg.finish[ccr_pkg::POS_SCALE]);  // see R3, R9
      cfg.timer_on <= tmr_code != 3'h0;  // see R4
      cfg.timer_hours <= (tmr_code == 3'h0) ? 4'h0 : 4'(int'(tmr_code) + HOUR_OFS);
      cfg.restart_mv <= RESTART_MV[cfg.input_limit[ccr_pkg::POS_RESTART]];  // see R5
      cfg.limit_on <= lim_code != LIM_OFF;  // see R6
      cfg.limit_ma <= (lim_code == LIM_OFF) ? 11'h000 : limit_ma(lim_code);
      cfg.trip_ma <= (lim_code == LIM_OFF) ? 11'h000 :
         11'((int'(limit_ma(lim_code)) * TRIP_PCT) / PCT);  // see R7
      cfg.finish_min <= 7'(int'(cfg.finish[ccr_pkg::POS_FTIMER +: ccr_pkg::W_FTIMER])
         * MIN_STEP);  // see R8
      cfg.finish_ma <= 8'((int'(cfg.finish[ccr_pkg::POS_FCUR +: ccr_pkg::W_FCUR]) + 1)
         * FCUR_STEP);  // see R10
      cfg.term_mv <= TERM_MV[cfg.finish[ccr_pkg::POS_TERM +: ccr_pkg::W_TERM]];  // see R11
      cfg.setpt_on <= set_code != SETPT_OFF;  // see R12
      cfg.setpt_c <= SETPT_C[set_code];
   end
endmodule

//--- hw/ccr_config_bank.sv
// Top of the charger configuration register bank with its register port
`timescale 1ns/1ps
module ccr_config_bank #(
   parameter int THERM_OFF_RESET = 0
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Bank reset sources
   input wire logic i_standby_supply_valid,
   input wire logic i_safe_output_power_good,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Input control
   output logic o_input_voltage_watch_off,
   output logic o_low_power_standby_enable,
   // Fast charge
   output logic [11:0] o_charge_current_ma,
   output logic [3:0] o_charge_timer_hours,
   output logic o_charge_timer_on,
   output logic [7:0] o_recharge_drop_mv,
   // Input limit
   output logic [10:0] o_input_limit_ma,
   output logic [10:0] o_input_limit_trip_ma,
   output logic o_input_limit_on,
   // Finish phase
   output logic [6:0] o_finish_timer_min,
   output logic o_high_current_test_scale,
   output logic [7:0] o_finish_current_ma,
   output logic [12:0] o_termination_mv,
   // Thermal
   output logic [6:0] o_die_thermal_c,
   output logic o_die_thermal_on,
   output logic o_thermistor_watch_off,
   output logic o_safety_region_sel,
   // Lock state
   output logic o_settings_unlocked
);
   // ------------------------------------------------------------------
   // Parameter check and variant reset value
   // ------------------------------------------------------------------
   if (THERM_OFF_RESET < 0 || THERM_OFF_RESET > 1) begin : g_chk
      $error("THERM_OFF_RESET must be 0 or 1");
   end

   localparam logic [7:0] THERM_RST = ccr_pkg::RST_THERMAL |
      (8'(THERM_OFF_RESET) << ccr_pkg::POS_THERM_OFF);

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [7:0] ctl_q;
   logic [7:0] fast_q;
   logic [7:0] lim_q;
   logic [7:0] fin_q;
   logic [7:0] th_q;
   logic [7:0] lock_q;
   logic unlocked_q;
   logic clr;
   logic [7:0] rdata_d;

   ccr_cfg_if cfg();

   function automatic logic wr_to(input logic [7:0] ofs);
      return i_reg_wr && (i_reg_addr == ofs);
   endfunction

   // Guarded write only lands while the key is open
   function automatic logic wr_guard(input logic [7:0] ofs);
      return wr_to(ofs) && unlocked_q;
   endfunction

   // ------------------------------------------------------------------
   // Bank clear and decoder
   // ------------------------------------------------------------------
   ccr_bank_reset u_bank_reset (
      .i_clk_sys (i_clk_sys),
      .i_rst (i_rst),
      .i_standby_supply_valid (i_standby_supply_valid),
      .i_safe_output_power_good (i_safe_output_power_good),
      .o_bank_clear (clr)
   );

   assign cfg.fast_charge = fast_q;
   assign cfg.input_limit = lim_q;
   assign cfg.finish = fin_q;
   assign cfg.thermal = th_q;

   ccr_decode u_decode (
      .i_clk_sys (i_clk_sys),
      .cfg (cfg.dec)
   );

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R17
         ctl_q <= ccr_pkg::RST_CTL;
      end else if (wr_to(ccr_pkg::OFS_CTL)) begin  // see R1, R2, R16
         ctl_q <= i_reg_wdata & ccr_pkg::WMSK_CTL;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R17
         fast_q <= ccr_pkg::RST_FAST;
      end else if (wr_guard(ccr_pkg::OFS_FAST)) begin  // see R16, R18
         fast_q <= i_reg_wdata & ccr_pkg::WMSK_FAST;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R17
         lim_q <= ccr_pkg::RST_LIMIT;
      end else if (wr_guard(ccr_pkg::OFS_LIMIT)) begin  // see R16, R18
         lim_q <= i_reg_wdata & ccr_pkg::WMSK_LIMIT;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R17
         fin_q <= ccr_pkg::RST_FINISH;
      end else if (wr_guard(ccr_pkg::OFS_FINISH)) begin  // see R16, R18
         fin_q <= i_reg_wdata & ccr_pkg::WMSK_FINISH;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R13, R17
         th_q <= THERM_RST;
      end else if (wr_guard(ccr_pkg::OFS_THERMAL)) begin  // see R14, R16, R18
         th_q <= i_reg_wdata & ccr_pkg::WMSK_THERMAL;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || clr) begin  // see R15, R17
         lock_q <= ccr_pkg::RST_LOCK;
         unlocked_q <= 1'b0;
      end else if (wr_to(ccr_pkg::OFS_LOCK)) begin
         lock_q <= i_reg_wdata & ccr_pkg::WMSK_LOCK;
         unlocked_q <= i_reg_wdata[ccr_pkg::POS_KEY +: ccr_pkg::W_KEY]
            == ccr_pkg::KEY_OPEN;  // see R15
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   always_comb begin
      case (i_reg_addr)
         ccr_pkg::OFS_CTL: rdata_d = ctl_q;
         ccr_pkg::OFS_FAST: rdata_d = fast_q;
         ccr_pkg::OFS_LIMIT: rdata_d = lim_q;
         ccr_pkg::OFS_FINISH: rdata_d = fin_q;
         ccr_pkg::OFS_THERMAL: rdata_d = th_q;
         ccr_pkg::OFS_LOCK: rdata_d = lock_q;
         default: rdata_d = ccr_pkg::RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata <= ccr_pkg::RD_UNMAPPED;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin  // see R18
            o_reg_rdata <= rdata_d;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_input_voltage_watch_off = ctl_q[ccr_pkg::POS_WATCH_OFF];  // see R1
   assign o_low_power_standby_enable = ctl_q[ccr_pkg::POS_STANDBY];  // see R2
   assign o_high_current_test_scale = fin_q[ccr_pkg::POS_SCALE];  // see R9
   assign o_thermistor_watch_off = th_q[ccr_pkg::POS_THERM_OFF];  // see R13
   assign o_safety_region_sel = th_q[ccr_pkg::POS_SAFETY];  // see R14
   assign o_settings_unlocked = unlocked_q;
   assign o_charge_current_ma = cfg.charge_ma;
   assign o_charge_timer_hours = cfg.timer_hours;
   assign o_charge_timer_on = cfg.timer_on;
   assign o_recharge_drop_mv = cfg.restart_mv;
   assign o_input_limit_ma = cfg.limit_ma;
   assign o_input_limit_trip_ma = cfg.trip_ma;
   assign o_input_limit_on = cfg.limit_on;
   assign o_finish_timer_min = cfg.finish_min;
   assign o_finish_current_ma = cfg.finish_ma;
   assign o_termination_mv = cfg.term_mv;
   assign o_die_thermal_c = cfg.setpt_c;
   assign o_die_thermal_on = cfg.setpt_on;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   a_watch_off_set: assert property ( // see R1
      wr_to(ccr_pkg::OFS_CTL) && !clr && i_reg_wdata[ccr_pkg::POS_WATCH_OFF]
      |=> o_input_voltage_watch_off)
      else $error("watch-off bit not taken");

   a_standby_clear: assert property ( // see R2
      wr_to(ccr_pkg::OFS_CTL) && !clr && !i_reg_wdata[ccr_pkg::POS_STANDBY]
      |=> !o_low_power_standby_enable)
      else $error("standby bit not cleared");

   a_charge_floor: assert property ( // see R3
      fast_q[ccr_pkg::POS_CUR +: ccr_pkg::W_CUR] <= 5'h05 && !fin_q[ccr_pkg::POS_SCALE]
      |=> o_charge_current_ma == 12'h0fa)
      else $error("low charge codes not at 250mA");

   a_charge_top: assert property ( // see R3
      fast_q[ccr_pkg::POS_CUR +: ccr_pkg::W_CUR] == 5'h1f && !fin_q[ccr_pkg::POS_SCALE]
      |=> o_charge_current_ma == 12'h60e)
      else $error("top charge code not at 1550mA");

   a_timer_off: assert property ( // see R4
      fast_q[ccr_pkg::POS_TIMER +: ccr_pkg::W_TIMER] == 3'h0
      |=> !o_charge_timer_on && o_charge_timer_hours == 4'h0)
      else $error("timer code 0 not disabled");

   a_timer_top: assert property ( // see R4
      fast_q[ccr_pkg::POS_TIMER +: ccr_pkg::W_TIMER] == 3'h7
      |=> o_charge_timer_on && o_charge_timer_hours == 4'ha)
      else $error("timer code 7 not 10 hours");

   a_restart_sel: assert property ( // see R5
      lim_q[ccr_pkg::POS_RESTART] |=> o_recharge_drop_mv == 8'h64)
      else $error("restart select not 100mV");

   a_limit_top: assert property ( // see R6, R7
      lim_q[ccr_pkg::POS_LIMIT +: ccr_pkg::W_LIMIT] == 6'h3c
      |=> o_input_limit_ma == 11'h5dc && o_input_limit_trip_ma == 11'h591)
      else $error("limit code 60 wrong");

   a_limit_low: assert property ( // see R6
      lim_q[ccr_pkg::POS_LIMIT +: ccr_pkg::W_LIMIT] <= 6'h09
      |=> o_input_limit_on && o_input_limit_ma == 11'h064)
      else $error("low limit codes not at 100mA");

   a_limit_off: assert property ( // see R6
      lim_q[ccr_pkg::POS_LIMIT +: ccr_pkg::W_LIMIT] == 6'h3f |=> !o_input_limit_on)
      else $error("limit all-ones not disabled");

   a_trip_ratio: assert property ( // see R7
      o_input_limit_on |->
      32'(o_input_limit_trip_ma) * 32'h64 <= 32'(o_input_limit_ma) * 32'h5f &&
      (32'(o_input_limit_trip_ma) + 32'h1) * 32'h64 > 32'(o_input_limit_ma) * 32'h5f)
      else $error("trip point not 95 percent");

   a_finish_timer: assert property ( // see R8
      fin_q[ccr_pkg::POS_FTIMER +: ccr_pkg::W_FTIMER] == 3'h7
      |=> o_finish_timer_min == 7'h46)
      else $error("finish timer code 7 not 70min");

   a_test_scale: assert property ( // see R9
      fin_q[ccr_pkg::POS_SCALE] |=> o_charge_current_ma == 12'haf0)
      else $error("test scale not 2800mA");

   a_finish_current: assert property ( // see R10
      fin_q[ccr_pkg::POS_FCUR +: ccr_pkg::W_FCUR] == 2'h3 |=> o_finish_current_ma == 8'hc8)
      else $error("finish current code 3 not 200mA");

   a_term_voltage: assert property ( // see R11
      fin_q[ccr_pkg::POS_TERM +: ccr_pkg::W_TERM] == 2'h2 |=> o_termination_mv == 13'h10fe)
      else $error("termination code 2 not 4350mV");

   a_setpt_decode: assert property ( // see R12
      th_q[ccr_pkg::POS_SETPT +: ccr_pkg::W_SETPT] == 2'h1
      |=> o_die_thermal_on && o_die_thermal_c == 7'h5a)
      else $error("setpoint code 1 not 90C");

   a_setpt_off: assert property ( // see R12
      th_q[ccr_pkg::POS_SETPT +: ccr_pkg::W_SETPT] == 2'h3 |=> !o_die_thermal_on)
      else $error("setpoint code 3 not disabled");

   a_therm_default: assert property ( // see R13
      clr |=> o_thermistor_watch_off == THERM_RST[ccr_pkg::POS_THERM_OFF])
      else $error("thermistor watch default wrong");

   a_safety_write: assert property ( // see R14
      wr_guard(ccr_pkg::OFS_THERMAL) && !clr && i_reg_wdata[ccr_pkg::POS_SAFETY]
      |=> o_safety_region_sel)
      else $error("safety region not taken");

   a_key_open: assert property ( // see R15
      wr_to(ccr_pkg::OFS_LOCK) && !clr &&
      i_reg_wdata[ccr_pkg::POS_KEY +: ccr_pkg::W_KEY] == ccr_pkg::KEY_OPEN
      |=> o_settings_unlocked)
      else $error("key 11 did not unlock");

   a_key_close: assert property ( // see R15
      wr_to(ccr_pkg::OFS_LOCK) &&
      i_reg_wdata[ccr_pkg::POS_KEY +: ccr_pkg::W_KEY] != ccr_pkg::KEY_OPEN
      |=> !o_settings_unlocked)
      else $error("other key did not lock");

   a_locked_hold: assert property ( // see R16, R18
      i_reg_wr && !unlocked_q && !clr &&
      i_reg_addr inside {[ccr_pkg::OFS_FAST : ccr_pkg::OFS_THERMAL]}
      |=> $stable(fast_q) && $stable(lim_q) && $stable(fin_q) && $stable(th_q))
      else $error("locked write changed a guarded register");

   a_open_write: assert property ( // see R16
      wr_guard(ccr_pkg::OFS_FAST) && !clr |=> fast_q == $past(i_reg_wdata))
      else $error("unlocked write not stored");

   a_bank_default: assert property ( // see R17
      clr |=> ctl_q == ccr_pkg::RST_CTL && fast_q == ccr_pkg::RST_FAST &&
      lim_q == ccr_pkg::RST_LIMIT && fin_q == ccr_pkg::RST_FINISH &&
      th_q == THERM_RST && lock_q == ccr_pkg::RST_LOCK && !o_settings_unlocked)
      else $error("bank clear did not restore defaults");

   a_read_back: assert property ( // see R18
      i_reg_rd && i_reg_addr == ccr_pkg::OFS_FAST
      |=> o_reg_rvalid && o_reg_rdata == $past(fast_q))
      else $error("read data wrong");

   a_read_pulse: assert property (
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("read valid without read");

   c_open_write: cover property (wr_guard(ccr_pkg::OFS_LIMIT) && !clr);
   c_locked_write: cover property (wr_to(ccr_pkg::OFS_FINISH) && !unlocked_q && !clr);
   c_limit_off: cover property (o_input_limit_on ##1 !o_input_limit_on);
   c_bank_clear: cover property (o_settings_unlocked ##1 clr);
   c_test_scale: cover property ($rose(o_high_current_test_scale));
endmodule

//--- verif/ccr_host_model.sv
// Host model that drives the register port with one-cycle strobes
`timescale 1ns/1ps
module ccr_host_model (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic [7:0] o_reg_addr = 8'h00,
   output logic [7:0] o_reg_wdata = 8'h00,
   output logic o_reg_wr = 1'b0,
   output logic o_reg_rd = 1'b0
);
   // Released address and data show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      {o_reg_addr, o_reg_wdata, o_reg_wr} <= {a, d, 1'b1};
      @(posedge i_clk_sys);
      {o_reg_addr, o_reg_wdata, o_reg_wr} <= {~a, ~d, 1'b0};
      // Decoded outputs settle one edge after the taking edge
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge i_clk_sys);
      {o_reg_addr, o_reg_rd} <= {a, 1'b1};
      @(posedge i_clk_sys);
      {o_reg_addr, o_reg_rd} <= {~a, 1'b0};
      @(posedge i_clk_sys);
      {d, v} = {i_reg_rdata, i_reg_rvalid};
   endtask
endmodule

//--- verif/charger_config_register_bank_tb.sv
// Self-checking bench of the charger configuration register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin $display("wrong value %s exp %0h got %0h", n, e, s); err_count++; end end
module charger_config_register_bank_tb;
   int err_count = 0, cmp_count = 0;
   logic clk = 1'b0, rst = 1'b1, sb = 1'b1, pg = 1'b0;
   logic wr, rd, rv, wof, lps, unl, v, ton, lon, tsc, don, two, srs;
   logic [3:0] thr;
   logic [7:0] adr, wd, rdat, rb, rmv, fma;
   logic [11:0] cma;
   logic [10:0] lma, tma;
   logic [6:0] fmin, dc;
   logic [12:0] tmv;
   always #2 clk = ~clk;
   ccr_config_bank dut (.i_clk_sys(clk), .i_rst(rst), .i_standby_supply_valid(sb),
      .i_safe_output_power_good(pg), .i_reg_addr(adr), .i_reg_wr(wr), .i_reg_wdata(wd),
      .i_reg_rd(rd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_input_voltage_watch_off(wof),
      .o_low_power_standby_enable(lps), .o_charge_current_ma(cma),
      .o_charge_timer_hours(thr), .o_charge_timer_on(ton), .o_recharge_drop_mv(rmv),
      .o_input_limit_ma(lma), .o_input_limit_trip_ma(tma), .o_input_limit_on(lon),
      .o_finish_timer_min(fmin), .o_high_current_test_scale(tsc), .o_finish_current_ma(fma),
      .o_termination_mv(tmv), .o_die_thermal_c(dc), .o_die_thermal_on(don),
      .o_thermistor_watch_off(two), .o_safety_region_sel(srs), .o_settings_unlocked(unl));
   ccr_host_model host (.i_clk_sys(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
      .o_reg_addr(adr), .o_reg_wdata(wd), .o_reg_wr(wr), .o_reg_rd(rd));
   // Read data and its valid pulse are judged together
   task automatic get(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rb, v);
      `CHK("rdata", {e, 1'b1}, {rb, v})
   endtask
   task automatic t_defaults;
      get(8'h06, 8'h4a);
      get(8'h07, 8'h14);
      get(8'h08, 8'h60);
      get(8'h09, 8'h00);
      get(8'h0a, 8'h00);
      get(8'h0b, 8'h00);
      `CHK("current", 12'h1f4, cma)
      `CHK("hours", 4'h5, thr)
      `CHK("timer on", 1'b1, ton)
      `CHK("drop", 8'h96, rmv)
      `CHK("limit", 11'h1f4, lma)
      `CHK("trip", 11'h1db, tma)
      `CHK("finish", 7'h1e, fmin)
      `CHK("scaled", 1'b0, tsc)
      `CHK("fcur", 8'h32, fma)
      `CHK("term", 13'h1068, tmv)
      `CHK("die c", 7'h69, dc)
      `CHK("die on", 1'b1, don)
      `CHK("therm off", 1'b0, two)
      `CHK("region", 1'b0, srs)
      `CHK("unlocked", 1'b0, unl)
   endtask
   task automatic t_lock;
      host.wr(8'h0a, 8'h0c);
      `CHK("unlocked", 1'b1, unl)
      host.wr(8'h06, 8'h1f);
      `CHK("current", 12'h60e, cma)
      `CHK("timer on", 1'b0, ton)
      `CHK("hours", 4'h0, thr)
      host.wr(8'h07, 8'h4a);
      `CHK("limit", 11'h0fa, lma)
      `CHK("limit on", 1'b1, lon)
      `CHK("trip", 11'h0ed, tma)
      `CHK("drop", 8'h64, rmv)
      host.wr(8'h08, 8'hfd);
      `CHK("finish", 7'h46, fmin)
      `CHK("scaled", 12'haf0, cma)
      `CHK("scale bit", 1'b1, tsc)
      `CHK("fcur", 8'hc8, fma)
      `CHK("term", 13'h1004, tmv)
      host.wr(8'h09, 8'hc9);
      get(8'h09, 8'hc9);
      `CHK("die on", 1'b0, don)
      `CHK("die c", 7'h00, dc)
      `CHK("therm off", 1'b1, two)
      `CHK("region", 1'b1, srs)
      host.wr(8'h0a, 8'h08);
      host.wr(8'h07, 8'h3f);
      `CHK("unlocked", 1'b0, unl)
      get(8'h07, 8'h4a);
      host.wr(8'h0a, 8'h0c);
      host.wr(8'h07, 8'h3f);
      `CHK("limit on", 1'b0, lon)
      `CHK("trip", 11'h000, tma)
   endtask
   task automatic t_clear;
      host.wr(8'h05, 8'h03);
      `CHK("watch", 1'b1, wof)
      `CHK("standby", 1'b1, lps)
      @(posedge clk);
      pg <= 1'b1;
      repeat (4) @(posedge clk);
      get(8'h05, 8'h00);
      `CHK("unlocked", 1'b0, unl)
      `CHK("region", 1'b0, srs)
      host.wr(8'h05, 8'h01);
      `CHK("watch", 1'b0, wof)
      `CHK("standby", 1'b1, lps)
      @(posedge clk);
      sb <= 1'b0;
      @(posedge clk);
      sb <= 1'b1;
      repeat (4) @(posedge clk);
      get(8'h05, 8'h00);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_defaults;
      t_lock;
      t_clear;
      tally_and_finish;
   end
   initial begin
      #20000;
      err_count++;
      tally_and_finish;
   end
endmodule
